// ---- pkg/twm_pkg.sv ----
package twm_pkg;

    // Bus geometry
    localparam int WB_AW = 12;
    localparam int WB_DW = 32;

    // Register byte offsets
    localparam logic [11:0] OFF_STARTRX  = 12'h000;
    localparam logic [11:0] OFF_STARTTX  = 12'h008;
    localparam logic [11:0] OFF_STOP     = 12'h014;
    localparam logic [11:0] OFF_SUSPEND  = 12'h01c;
    localparam logic [11:0] OFF_RESUME   = 12'h020;
    localparam logic [11:0] OFF_EVENT_TASK_LINKS   = 12'h200;
    localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] OFF_FAULT    = 12'h4c4;
    localparam logic [11:0] OFF_ENABLE   = 12'h500;
    localparam logic [11:0] OFF_PSELSCL  = 12'h508;
    localparam logic [11:0] OFF_PSELSDA  = 12'h50c;
    localparam logic [11:0] OFF_RXBYTE   = 12'h518;
    localparam logic [11:0] OFF_TXBYTE   = 12'h51c;
    localparam logic [11:0] OFF_RATE     = 12'h524;
    localparam logic [11:0] OFF_SLAVE    = 12'h588;

    // Events: index, offset and interrupt enable bit
    localparam int EV_N       = 6;
    localparam int EV_STOPPED = 0;
    localparam int EV_RXBYTE  = 1;
    localparam int EV_TXSENT  = 2;
    localparam int EV_ERROR   = 3;
    localparam int EV_BOUND   = 4;
    localparam int EV_SUSP    = 5;
    localparam logic [11:0] EVT_OFF [EV_N] = '{12'h104, 12'h108, 12'h11c,
                                              12'h124, 12'h138, 12'h148};
    localparam int INT_BIT [EV_N] = '{1, 2, 7, 9, 14, 18};

    // Field positions and values
    localparam int SH_BB_SUSPEND = 0;
    localparam int SH_BB_STOP    = 1;
    localparam int ERR_ANACK     = 1;
    localparam int ERR_DNACK     = 2;
    localparam int RATE_FAST_BIT = 0;
    localparam logic [3:0]  EN_ON      = 4'h5;
    localparam logic [3:0]  EN_RST     = 4'h0;
    localparam logic [31:0] PSEL_RST   = 32'hffff_ffff;
    localparam logic [31:0] ZERO32     = 32'h0000_0000;

    // Bus timing: one quarter of a serial bit, rounded up
    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int RATE_SLOW_HZ = 100_000;
    localparam int RATE_FAST_HZ = 400_000;
    localparam logic [7:0] QTR_SLOW_CYC =
        8'((SYS_CLK_HZ + 4 * RATE_SLOW_HZ - 1) / (4 * RATE_SLOW_HZ));
    localparam logic [7:0] QTR_FAST_CYC =
        8'((SYS_CLK_HZ + 4 * RATE_FAST_HZ - 1) / (4 * RATE_FAST_HZ));

    // Engine states
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b000_0001,
        ST_START  = 7'b000_0010,
        ST_BYTE   = 7'b000_0100,
        ST_WAITRX = 7'b000_1000,
        ST_DECIDE = 7'b001_0000,
        ST_SUSP   = 7'b010_0000,
        ST_STOP   = 7'b100_0000
    } twm_state_e;

    // Pin pair carrier
    typedef struct packed {
        logic scl;
        logic sda;
    } twm_pins_s;

endpackage

// ---- hdl/twm_master.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// - A write of 1 to the receive-start task starts a read sequence on the bus.
// - A write of 1 to the transmit-start task starts a write sequence on the bus.
// - A write of 1 to the stop task ends the transaction and then sets the stopped event.
// - The suspend task pauses at the next byte boundary with the suspended event; resume continues.
// - A byte-boundary event is raised before every byte sent or received.
// - The shortcut register links the byte-boundary event to the suspend and stop tasks.
// - The slave address of each transfer comes from the slave address register.
// - The rate register selects the serial clock rate derived from the system clock.
// - A not-acknowledge from the slave raises the error event.
// - A start condition is followed by the address and a direction bit, 0 write and 1 read.
// - With no fresh transmit byte the serial clock is held low until one is written.
// - After each received byte the clock is held and the acknowledge waits for a data read.
module twm_master (
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [twm_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [twm_pkg::WB_DW-1:0] wb_dat_i,
    output logic      [twm_pkg::WB_DW-1:0] wb_dat_o,
    output logic                          wb_ack_o,
    output logic                          irq_o,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          scl_o,
    output logic                          scl_oe_o,
    output logic                          sda_o,
    output logic                          sda_oe_o
);
    import twm_pkg::*;

    // Word address match
    function automatic logic hit(input logic [11:0] adr, input logic [11:0] off);
        hit = (adr[11:2] == off[11:2]);
    endfunction

    twm_state_e     st_r, st_nxt;
    twm_pins_s      s1_r, s2_r, oe_r, oe_nxt;
    logic [1:0]     ph_r, ph_nxt;
    logic [3:0]     bit_r, bit_nxt;
    logic [7:0]     sh_r, sh_nxt, rxd_r, rxd_nxt, txd_r, cnt_r;
    logic           dir_r, dir_nxt, drive_r, drive_nxt, first_r, first_nxt;
    logic           nack_r, nack_nxt, ackin_r, ackin_nxt;
    logic           p_stop_r, p_stop_nxt, p_start_r, p_start_nxt;
    logic           p_dir_r, p_dir_nxt, p_susp_r, p_susp_nxt;
    logic           tx_full_r, tx_take;
    logic [EV_N-1:0] evp_r, evp_nxt, evt_r, inten_r, ev_clr;
    logic [2:1]     err_r, err_set;
    logic [1:0]     event_task_links_r;
    logic [3:0]     enable_r;
    logic [31:0]    psel_scl_r, psel_sda_r, rate_r, rdata, inten_rd;
    logic [6:0]     slave_r;

    // Bus access decode
    wire        acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr       = acc & wb_we_i;
    wire        rd_rx    = acc & ~wb_we_i & hit(wb_adr_i, OFF_RXBYTE);
    wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wval     = wb_dat_i & wmask;
    wire        wr_tx    = wr & hit(wb_adr_i, OFF_TXBYTE) & wb_sel_i[0];
    wire        enabled  = (enable_r == EN_ON);

    // Task strobes, one cycle, only for a written 1
    wire t_rx   = wr & hit(wb_adr_i, OFF_STARTRX) & wval[0];
    wire t_tx   = wr & hit(wb_adr_i, OFF_STARTTX) & wval[0];
    wire t_stop = wr & hit(wb_adr_i, OFF_STOP) & wval[0];
    wire t_susp = wr & hit(wb_adr_i, OFF_SUSPEND) & wval[0];
    wire t_res  = wr & hit(wb_adr_i, OFF_RESUME) & wval[0];

    // Shortcuts from the byte boundary event
    wire sh_susp = evp_r[EV_BOUND] & event_task_links_r[SH_BB_SUSPEND];
    wire sh_stop = evp_r[EV_BOUND] & event_task_links_r[SH_BB_STOP];

    // Quarter-bit tick at the selected rate
    wire [7:0] qtr  = rate_r[RATE_FAST_BIT] ? QTR_FAST_CYC : QTR_SLOW_CYC;
    wire       tick = (cnt_r == qtr - 8'd1);

    // Event clear decode and interrupt enable readback
    genvar g;
    generate
        for (g = 0; g < EV_N; g++) begin : g_ev
            assign ev_clr[g] = wr & hit(wb_adr_i, EVT_OFF[g]) & wval[0];
        end
    endgenerate
    always_comb begin
        inten_rd = ZERO32;
        for (int i = 0; i < EV_N; i++) begin
            inten_rd[INT_BIT[i]] = inten_r[i];
        end
    end

    // Read data selection
    always_comb begin
        rdata = ZERO32;
        for (int i = 0; i < EV_N; i++) begin
            if (hit(wb_adr_i, EVT_OFF[i])) begin
                rdata = {31'h0000_0000, evt_r[i]};
            end
        end
        if (hit(wb_adr_i, OFF_EVENT_TASK_LINKS))   rdata = {30'h0000_0000, event_task_links_r};
        if (hit(wb_adr_i, OFF_IRQ_ENABLE_SET) || hit(wb_adr_i, OFF_IRQ_ENABLE_CLEAR)) rdata = inten_rd;
        if (hit(wb_adr_i, OFF_FAULT))    rdata = {29'h0000_0000, err_r, 1'b0};
        if (hit(wb_adr_i, OFF_ENABLE))   rdata = {28'h000_0000, enable_r};
        if (hit(wb_adr_i, OFF_PSELSCL))  rdata = psel_scl_r;
        if (hit(wb_adr_i, OFF_PSELSDA))  rdata = psel_sda_r;
        if (hit(wb_adr_i, OFF_RXBYTE))   rdata = {24'h00_0000, rxd_r};
        if (hit(wb_adr_i, OFF_TXBYTE))   rdata = {24'h00_0000, txd_r};
        if (hit(wb_adr_i, OFF_RATE))     rdata = rate_r;
        if (hit(wb_adr_i, OFF_SLAVE))    rdata = {25'h000_0000, slave_r};
    end

    // Serial engine next state
    always_comb begin
        st_nxt = st_r;
        oe_nxt = oe_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        rxd_nxt = rxd_r;
        dir_nxt = dir_r;
        drive_nxt = drive_r;
        first_nxt = first_r;
        nack_nxt = nack_r;
        ackin_nxt = ackin_r;
        evp_nxt = '0;
        err_set = '0;
        tx_take = 1'b0;
        p_stop_nxt = p_stop_r | t_stop | sh_stop;
        p_start_nxt = p_start_r | t_rx | t_tx;
        p_dir_nxt = t_rx ? 1'b1 : (t_tx ? 1'b0 : p_dir_r);
        p_susp_nxt = (p_susp_r | t_susp | sh_susp) & ~t_res;
        case (st_r)
            ST_IDLE: begin
                oe_nxt = '0;
                if (p_stop_r) begin
                    p_stop_nxt = 1'b0;
                    evp_nxt[EV_STOPPED] = 1'b1;
                end else if (p_start_r) begin
                    p_start_nxt = 1'b0;
                    if (enabled) begin
                        st_nxt = ST_START;
                        ph_nxt = 2'd0;
                        dir_nxt = p_dir_r;
                        sh_nxt = {slave_r, p_dir_r};
                        first_nxt = 1'b1;
                        drive_nxt = 1'b1;
                    end
                end
            end
            ST_START: begin
                if (tick) begin
                    case (ph_r)
                        2'd0: begin
                            oe_nxt.sda = 1'b0;
                            ph_nxt = 2'd1;
                        end
                        2'd1: begin
                            oe_nxt.scl = 1'b0;
                            if (s2_r.scl) ph_nxt = 2'd2;
                        end
                        2'd2: begin
                            oe_nxt.sda = 1'b1;
                            ph_nxt = 2'd3;
                        end
                        default: begin
                            oe_nxt.scl = 1'b1;
                            st_nxt = ST_BYTE;
                            ph_nxt = 2'd0;
                            bit_nxt = 4'd0;
                            evp_nxt[EV_BOUND] = 1'b1;
                        end
                    endcase
                end
            end
            ST_BYTE: begin
                if (tick) begin
                    case (ph_r)
                        2'd0: begin
                            if (bit_r < 4'd8) oe_nxt.sda = drive_r & ~sh_r[7];
                            else oe_nxt.sda = ~drive_r & ~nack_r;
                            ph_nxt = 2'd1;
                        end
                        2'd1: begin
                            oe_nxt.scl = 1'b0;
                            if (s2_r.scl) ph_nxt = 2'd2;
                        end
                        2'd2: begin
                            if (bit_r < 4'd8) sh_nxt = {sh_r[6:0], s2_r.sda};
                            else ackin_nxt = s2_r.sda;
                            ph_nxt = 2'd3;
                        end
                        default: begin
                            oe_nxt.scl = 1'b1;
                            ph_nxt = 2'd0;
                            if (bit_r == 4'd7 && !drive_r) begin
                                st_nxt = ST_WAITRX;
                                rxd_nxt = sh_r;
                                bit_nxt = 4'd8;
                                evp_nxt[EV_RXBYTE] = 1'b1;
                            end else if (bit_r == 4'd8) begin
                                st_nxt = ST_DECIDE;
                                first_nxt = 1'b0;
                                if (drive_r && ackin_r) begin
                                    evp_nxt[EV_ERROR] = 1'b1;
                                    err_set[first_r ? ERR_ANACK : ERR_DNACK] = 1'b1;
                                end
                                if (drive_r && !first_r) evp_nxt[EV_TXSENT] = 1'b1;
                            end else begin
                                bit_nxt = bit_r + 4'd1;
                            end
                        end
                    endcase
                end
            end
            ST_WAITRX: begin
                if (rd_rx) begin
                    st_nxt = ST_BYTE;
                    ph_nxt = 2'd0;
                    nack_nxt = p_stop_nxt | p_start_nxt;
                end
            end
            ST_DECIDE: begin
                if (p_stop_r) begin
                    p_stop_nxt = 1'b0;
                    st_nxt = ST_STOP;
                    ph_nxt = 2'd0;
                end else if (p_start_r) begin
                    p_start_nxt = 1'b0;
                    st_nxt = ST_START;
                    ph_nxt = 2'd0;
                    dir_nxt = p_dir_r;
                    sh_nxt = {slave_r, p_dir_r};
                    first_nxt = 1'b1;
                    drive_nxt = 1'b1;
                end else if (p_susp_r) begin
                    p_susp_nxt = 1'b0;
                    st_nxt = ST_SUSP;
                    evp_nxt[EV_SUSP] = 1'b1;
                end else if (dir_r) begin
                    st_nxt = ST_BYTE;
                    drive_nxt = 1'b0;
                    nack_nxt = 1'b0;
                    bit_nxt = 4'd0;
                    ph_nxt = 2'd0;
                    evp_nxt[EV_BOUND] = 1'b1;
                end else if (tx_full_r) begin
                    tx_take = 1'b1;
                    sh_nxt = txd_r;
                    st_nxt = ST_BYTE;
                    drive_nxt = 1'b1;
                    bit_nxt = 4'd0;
                    ph_nxt = 2'd0;
                    evp_nxt[EV_BOUND] = 1'b1;
                end
            end
            ST_SUSP: begin
                if (t_res || p_stop_r) st_nxt = ST_DECIDE;
            end
            ST_STOP: begin
                if (tick) begin
                    case (ph_r)
                        2'd0: begin
                            oe_nxt.sda = 1'b1;
                            ph_nxt = 2'd1;
                        end
                        2'd1: begin
                            oe_nxt.scl = 1'b0;
                            if (s2_r.scl) ph_nxt = 2'd2;
                        end
                        2'd2: begin
                            oe_nxt.sda = 1'b0;
                            ph_nxt = 2'd3;
                        end
                        default: begin
                            st_nxt = ST_IDLE;
                            evp_nxt[EV_STOPPED] = 1'b1;
                        end
                    endcase
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    // Pin synchronisers and quarter-bit counter
    always_ff @(posedge clk_i) begin
        s1_r <= '{scl: scl_i, sda: sda_i};
        s2_r <= s1_r;
        cnt_r <= (rst_i || tick) ? 8'h00 : cnt_r + 8'h01;
    end

    // Serial engine registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            oe_r <= '0;
            {ph_r, bit_r, sh_r, rxd_r} <= '0;
            {dir_r, drive_r, first_r, nack_r, ackin_r} <= '0;
            {p_stop_r, p_start_r, p_dir_r, p_susp_r} <= '0;
            evp_r <= '0;
        end else begin
            st_r <= st_nxt;
            oe_r <= oe_nxt;
            {ph_r, bit_r, sh_r, rxd_r} <= {ph_nxt, bit_nxt, sh_nxt, rxd_nxt};
            {dir_r, drive_r, first_r} <= {dir_nxt, drive_nxt, first_nxt};
            {nack_r, ackin_r} <= {nack_nxt, ackin_nxt};
            {p_stop_r, p_start_r} <= {p_stop_nxt, p_start_nxt};
            {p_dir_r, p_susp_r} <= {p_dir_nxt, p_susp_nxt};
            evp_r <= evp_nxt;
        end
    end

    // Events, fault cause and transmit holding; a set wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_r <= '0;
            err_r <= '0;
            tx_full_r <= 1'b0;
        end else begin
            evt_r <= (evt_r & ~ev_clr) | evp_r;
            err_r <= (err_r & ~(wr & hit(wb_adr_i, OFF_FAULT) ? wval[2:1] : 2'b00)) | err_set;
            tx_full_r <= wr_tx | (tx_full_r & ~tx_take);
        end
    end

    // Software configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inten_r <= '0;
            event_task_links_r <= '0;
            enable_r <= EN_RST;
            psel_scl_r <= PSEL_RST;
            psel_sda_r <= PSEL_RST;
            rate_r <= ZERO32;
            slave_r <= '0;
            txd_r <= '0;
        end else if (wr) begin
            for (int i = 0; i < EV_N; i++) begin
                if (hit(wb_adr_i, OFF_IRQ_ENABLE_SET) && wval[INT_BIT[i]]) inten_r[i] <= 1'b1;
                if (hit(wb_adr_i, OFF_IRQ_ENABLE_CLEAR) && wval[INT_BIT[i]]) inten_r[i] <= 1'b0;
            end
            if (hit(wb_adr_i, OFF_EVENT_TASK_LINKS))  event_task_links_r <= (event_task_links_r & ~wmask[1:0]) | wval[1:0];
            if (hit(wb_adr_i, OFF_ENABLE) && wb_sel_i[0]) enable_r <= wb_dat_i[3:0];
            if (hit(wb_adr_i, OFF_PSELSCL)) psel_scl_r <= (psel_scl_r & ~wmask) | wval;
            if (hit(wb_adr_i, OFF_PSELSDA)) psel_sda_r <= (psel_sda_r & ~wmask) | wval;
            if (hit(wb_adr_i, OFF_RATE))    rate_r <= (rate_r & ~wmask) | wval;
            if (hit(wb_adr_i, OFF_SLAVE) && wb_sel_i[0]) slave_r <= wb_dat_i[6:0];
            if (wr_tx) txd_r <= wb_dat_i[7:0];
        end
    end

    // Bus answer, interrupt and pin outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO32;
            irq_o <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= rdata;
            irq_o <= |(evt_r & inten_r);
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= oe_nxt.scl;
            sda_oe_o <= oe_nxt.sda;
        end
    end

endmodule

`default_nettype wire

// ---- test/twm_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none

// Port-level checks for the two-wire master
module twm_monitor (
    input wire logic                       clk_i,
    input wire logic                       rst_i,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [twm_pkg::WB_AW-1:0]  wb_adr_i,
    input wire logic [3:0]                 wb_sel_i,
    input wire logic [twm_pkg::WB_DW-1:0]  wb_dat_i,
    input wire logic [twm_pkg::WB_DW-1:0]  wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire logic                       irq_o,
    input wire logic                       scl_i,
    input wire logic                       sda_i,
    input wire logic                       scl_o,
    input wire logic                       scl_oe_o,
    input wire logic                       sda_o,
    input wire logic                       sda_oe_o
);
    import twm_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [15:0] hi_cnt_r;
    logic        mask_on_r;
    wire         req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         wr_ok = req & wb_we_i;

    // Released clock time and a conservative view of the interrupt mask
    always_ff @(posedge clk_i) begin
        hi_cnt_r <= (rst_i | scl_oe_o) ? 16'h0000 : hi_cnt_r + 16'h0001;
        if (rst_i)
            mask_on_r <= 1'b0;
        else if (wr_ok && wb_adr_i == OFF_IRQ_ENABLE_SET && wb_dat_i != ZERO32)
            mask_on_r <= 1'b1;
        else if (wr_ok && wb_adr_i == OFF_IRQ_ENABLE_CLEAR && wb_dat_i == 32'hffff_ffff)
            mask_on_r <= 1'b0;
    end

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_latency: assert property (req |=> wb_ack_o)
        else $error("ack late");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !irq_o && !scl_oe_o && !sda_oe_o)
        else $error("outputs active after reset");
    a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("line driven high");
    a_start_cond: assert property (
        $rose(sda_oe_o) && !scl_oe_o && scl_i |-> ##[1:300] scl_oe_o)
        else $error("start condition without clock low");
    a_scl_high_min: assert property ($rose(scl_oe_o) |-> hi_cnt_r >= 16'h0030)
        else $error("clock high phase too short");
    a_irq_masked: assert property (!mask_on_r [*4] |-> !irq_o)
        else $error("irq while masked");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 12'h7fc
        |=> wb_dat_o == ZERO32)
        else $error("unmapped read not zero");

    c_start: cover property ($rose(sda_oe_o) && scl_i);
    c_irq: cover property ($rose(irq_o));
    c_stop: cover property (wr_ok && wb_adr_i == OFF_STOP);
endmodule

`default_nettype wire

// ---- test/twm_slave.sv ----
`timescale 1ns/10ps
`default_nettype none

// Bus slave model: acks its address, stores writes, returns a fixed byte
module twm_slave #(
    parameter logic [6:0] ADDR  = 7'h2a,
    parameter logic [7:0] RDATA = 8'ha5
) (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       stretch_i,
    output logic            scl_oe_o,
    output logic            sda_oe_o,
    output logic [7:0]      last_o
);
    int         cnt    = 9;
    logic [7:0] sh     = 8'h00;
    logic       sel    = 1'b0;
    logic       rd     = 1'b0;
    logic       adr_ph = 1'b0;

    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        last_o   = 8'h00;
    end

    // Start and stop: data moves while the clock is high
    always @(sda_i) begin
        if (scl_i === 1'b1) begin
            cnt      = 0;
            adr_ph   = !sda_i;
            sel      = 1'b0;
            sda_oe_o = 1'b0;
        end
    end

    // Sample bits; a master not-acknowledge ends our read data
    always @(posedge scl_i) begin
        if (cnt < 8)
            sh = {sh[6:0], sda_i};
        if (cnt == 8 && rd && sda_i)
            sel = 1'b0;
        cnt = cnt + 1;
    end

    // Drive acknowledge or read data while the clock is low
    always @(negedge scl_i) begin
        if (cnt == 9)
            cnt = 0;
        if (cnt == 8) begin
            sda_oe_o = adr_ph ? (sh[7:1] == ADDR) : (sel & ~rd);
            if (adr_ph) begin
                sel = (sh[7:1] == ADDR);
                rd  = sh[0];
            end else if (!rd)
                last_o = sh;
            adr_ph = 1'b0;
        end else
            sda_oe_o = sel & rd & ~adr_ph & ~RDATA[7-cnt];
    end

    // Slow answer: hold the clock low after each falling edge
    always @(negedge scl_i) begin
        if (stretch_i) begin
            scl_oe_o = 1'b1;
            #1500 scl_oe_o = 1'b0;
        end
    end
endmodule

`default_nettype wire

// ---- test/twm_master_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

// Bench for the two-wire master
module twm_master_tb;
    import twm_pkg::*;
    logic             clk, rst, cyc, we, ack, irq, stretch;
    logic             m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
    logic [WB_AW-1:0] adr;
    logic [WB_DW-1:0] wdat, rdat;
    logic [7:0]       s_last;
    twm_pins_s        line;
    int               num_errors = 0;
    int               cmp_count = 0;
    int               cycles = 0;

    twm_master uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .scl_i(line.scl), .sda_i(line.sda), .scl_o(), .scl_oe_o(m_scl_oe),
        .sda_o(), .sda_oe_o(m_sda_oe));
    twm_slave slv (.scl_i(line.scl), .sda_i(line.sda), .stretch_i(stretch),
        .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .last_o(s_last));

    // Wired lines with pull-ups
    assign line = '{scl: ~(m_scl_oe | s_scl_oe), sda: ~(m_sda_oe | s_sda_oe)};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            num_errors++;
            final_report;
        end
    end

    task automatic final_report;
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic cycle held until acknowledge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, ZERO32, q);
        check(q, e);
    endtask

    task automatic wait_ev(input int e);
        logic [31:0] q;
        q = ZERO32;
        for (int i = 0; i < 4000 && q[0] !== 1'b1; i++)
            bus(1'b0, EVT_OFF[e], ZERO32, q);
        check(q, 32'h0000_0001);
    endtask

    task automatic clr_ev;
        for (int i = 0; i < EV_N; i++)
            wr(EVT_OFF[i], 32'h0000_0001);
    endtask

    task automatic t_regs;
        rchk(OFF_PSELSDA, PSEL_RST);
        rchk(OFF_ENABLE, ZERO32);
        rchk(12'h7fc, ZERO32);
        wr(OFF_SLAVE, 32'h0000_002a);
        rchk(OFF_SLAVE, 32'h0000_002a);
        wr(OFF_ENABLE, {28'h0, EN_ON});
        wr(OFF_RATE, 32'h0000_0001);
        wr(OFF_STARTTX, ZERO32);
        repeat (100) @(posedge clk);
        check({30'h0, m_scl_oe, m_sda_oe}, ZERO32);
    endtask

    task automatic t_write;
        wr(OFF_IRQ_ENABLE_SET, 32'h0000_0080);
        wr(OFF_STARTTX, 32'h0000_0001);
        wait_ev(EV_BOUND);
        repeat (2000) @(posedge clk);
        check({31'h0, line.scl}, ZERO32);
        wr(OFF_TXBYTE, 32'h0000_003c);
        wait_ev(EV_TXSENT);
        check({24'h0, s_last}, 32'h0000_003c);
        check({31'h0, irq}, 32'h0000_0001);
        wr(OFF_IRQ_ENABLE_CLEAR, 32'h0000_0080);
        @(posedge clk);
        check({31'h0, irq}, ZERO32);
        wr(OFF_IRQ_ENABLE_SET, 32'h0000_0080);
        wr(EVT_OFF[EV_TXSENT], 32'h0000_0001);
        repeat (4) @(posedge clk);
        check({31'h0, irq}, ZERO32);
        rchk(EVT_OFF[EV_ERROR], ZERO32);
        wr(OFF_IRQ_ENABLE_CLEAR, 32'hffff_ffff);
        wr(OFF_STOP, 32'h0000_0001);
        wait_ev(EV_STOPPED);
        clr_ev;
    endtask

    task automatic t_read;
        stretch <= 1'b1;
        wr(OFF_STARTRX, 32'h0000_0001);
        wr(OFF_SUSPEND, 32'h0000_0001);
        wait_ev(EV_SUSP);
        repeat (500) @(posedge clk);
        check({31'h0, line.scl}, ZERO32);
        wr(OFF_RESUME, 32'h0000_0001);
        wait_ev(EV_RXBYTE);
        repeat (1000) @(posedge clk);
        check({31'h0, line.scl}, ZERO32);
        wr(OFF_STOP, 32'h0000_0001);
        rchk(OFF_RXBYTE, 32'h0000_00a5);
        wait_ev(EV_STOPPED);
        stretch <= 1'b0;
        clr_ev;
    endtask

    task automatic t_faults;
        wr(OFF_EVENT_TASK_LINKS, 32'h0000_0002);
        wr(OFF_STARTTX, 32'h0000_0001);
        wait_ev(EV_STOPPED);
        rchk(EVT_OFF[EV_TXSENT], ZERO32);
        wr(OFF_EVENT_TASK_LINKS, ZERO32);
        clr_ev;
        wr(OFF_SLAVE, 32'h0000_0011);
        wr(OFF_STARTTX, 32'h0000_0001);
        wait_ev(EV_ERROR);
        rchk(OFF_FAULT, 32'h0000_0002);
        wr(OFF_FAULT, 32'h0000_0002);
        rchk(OFF_FAULT, ZERO32);
        wr(OFF_STOP, 32'h0000_0001);
        wait_ev(EV_STOPPED);
    endtask

    // Main sequence
    initial begin
        cyc     = 1'b0;
        we      = 1'b0;
        adr     = '0;
        wdat    = '0;
        stretch = 1'b0;
        rst     = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_write;
        t_read;
        t_faults;
        final_report;
    end
endmodule

bind twm_master twm_monitor mon (.*);

`default_nettype wire
